/* src/cmbm_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cmbm_regs.svh"

// Contract
// [R1] Transmit pin low dominant, high recessive
// [R2] Receive on port bit 0, transmit bit 1
// [R3] Three independent transmit buffers
// [R4] Two-entry receive FIFO, background and foreground
// [R5] Every buffer holds thirteen bytes
// [R6] Receive-full only for accepted good frame
// [R7] Accepted frame copied to foreground, flag set
// [R8] Host reads foreground, then clears receive-full
// [R9] Background overwritten by next frame regardless; code keeps it while an accepted frame waits there
// [R10] Own frames stay background unless loop-back
// [R11] Loop-back own frames treated as incoming
// [R12] Lost arbitration turns transmitter into receiver
// [R13] Accepted frame with both full: overrun
// [R14] Both full: transmit continues, receive dropped
// [R15] Each transmit buffer has 8-bit priority
// [R16] Host loads buffer, clears empty to send
// [R17] Sent frame sets empty flag, interrupt
// [R18] Smallest priority value transmits first
// [R19] Priority reselected at every arbitration
// [R20] Abort unsent frame: ack, empty, interrupt
// [R21] Abort ack one if aborted, zero if sent
// [R22] Write-one clears; ignored while condition holds
// [R23] Ignore abort on empty; drop request when done
module cmbm_top
#(
	parameter int BUF_BYTES  = `CMBM_BUF_BYTES,
	parameter int FIFO_DEPTH = `CMBM_FIFO_DEPTH
) (
	input  wire logic              i_core_clk,
	input  wire logic              i_resetn,
	input  wire logic [1:0]        i_port_can_in,
	output logic      [1:0]        o_port_can_out,
	output logic      [1:0]        o_port_can_oe,
	output logic                   o_rx_level,
	input  wire logic              i_tx_level,
	input  wire logic              i_loopback,
	input  wire logic              i_rx_sof,
	input  wire logic              i_rx_byte_valid,
	input  wire cmbm_pkg::cmbm_byte_t i_rx_byte,
	output logic                   o_rx_byte_ready,
	input  wire logic              i_rx_frame_ok,
	input  wire logic              i_rx_error,
	input  wire logic              i_rx_accept,
	input  wire logic              i_rx_own,
	output logic                   o_ack_allow,
	input  wire logic              i_arb_start,
	input  wire logic              i_arb_lost,
	input  wire logic              i_tx_done,
	input  wire logic              i_tx_error,
	output logic                   o_tx_active,
	output cmbm_pkg::cmbm_idx_t    o_tx_sel,
	input  wire cmbm_pkg::cmbm_addr_t i_tx_byte_idx,
	output cmbm_pkg::cmbm_byte_t   o_tx_byte,
	input  wire logic              i_host_tx_wr,
	input  wire cmbm_pkg::cmbm_idx_t i_host_tx_buf,
	input  wire cmbm_pkg::cmbm_addr_t i_host_addr,
	input  wire cmbm_pkg::cmbm_byte_t i_host_wdata,
	input  wire logic              i_host_local_priority_field_wr,
	input  wire cmbm_pkg::cmbm_addr_t i_host_rx_addr,
	output cmbm_pkg::cmbm_byte_t   o_host_rx_rdata,
	input  wire logic              i_rxf_clr,
	input  wire logic              i_ovr_clr,
	input  wire logic [2:0]        i_txe_clr,
	input  wire logic [2:0]        i_abort_set,
	input  wire logic              i_rxf_ie,
	input  wire logic              i_ovr_ie,
	input  wire logic [2:0]        i_txe_ie,
	output logic                   o_rx_full_flag,
	output logic                   o_overrun_flag,
	output logic      [2:0]        o_tx_empty_flag,
	output logic      [2:0]        o_abort_request_bit,
	output logic      [2:0]        o_abort_ack_bit,
	output logic                   o_rx_irq,
	output logic                   o_err_irq,
	output logic                   o_tx_irq
);
	import cmbm_pkg::*;

	cmbm_byte_t bg_q [BUF_BYTES], bg_d [BUF_BYTES];
	cmbm_byte_t fg_q [BUF_BYTES], fg_d [BUF_BYTES];
	cmbm_byte_t txb_q [3][BUF_BYTES], txb_d [3][BUF_BYTES];
	cmbm_byte_t local_priority_field_q [3], local_priority_field_d [3];
	cmbm_rx_e   rx_st_q, rx_st_d;
	cmbm_addr_t ptr_q, ptr_d;
	cmbm_idx_t  sel_q, sel_d, best;
	logic [2:0] txe_q, txe_d, req_q, req_d, ack_q, ack_d, rdy;
	logic       rxf_q, rxf_d, ovr_q, ovr_d, bgf_q, bgf_d;
	logic       blk_q, blk_d, acc_q, acc_d, own_q, own_d;
	logic       act_q, act_d, best_ok, copy_now, f_valid, f_ready;
	cmbm_byte_t f_data;
	logic [1:0] pin_q;
	cmbm_byte_t txo_q, rxo_q;
	logic       rxi_q, erri_q, txi_q, alw_q;

	// ----------------------------------------
	// Receive byte buffer
	// ----------------------------------------
	cmbm_fifo #(
		.WIDTH(`CMBM_FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.i_core_clk (i_core_clk),
		.i_resetn   (i_resetn),
		.i_in_valid (i_rx_byte_valid),
		.i_in_data  (i_rx_byte),
		.o_in_ready (o_rx_byte_ready),
		.o_out_valid(f_valid),
		.o_out_data (f_data),
		.i_out_ready(f_ready)
	);

	// Drain stalls while background moves to foreground
	assign copy_now = i_rxf_clr && rxf_q && bgf_q;         // [R22]
	assign f_ready  = !copy_now;

	// ----------------------------------------
	// Receive sequencing
	// ----------------------------------------
	always_comb begin
		bg_d     = bg_q;
		fg_d     = fg_q;
		rx_st_d  = rx_st_q;
		ptr_d    = ptr_q;
		rxf_d    = rxf_q;
		ovr_d    = ovr_q;
		bgf_d    = bgf_q;
		blk_d    = blk_q;
		acc_d    = acc_q;
		own_d    = own_q;
		if (i_rxf_clr && rxf_q) begin
			if (bgf_q) begin
				fg_d  = bg_q;                              // [R4]
				bgf_d = 1'b0;
			end else begin
				rxf_d = 1'b0;                              // [R8]
			end
		end
		if (i_ovr_clr) begin
			ovr_d = 1'b0;
		end
		case (rx_st_q)
			CMBM_RX_IDLE: begin
				if (i_rx_sof) begin
					// Overwrite unless an accepted frame waits in background
					rx_st_d = CMBM_RX_RECV;                 // [R9]
					ptr_d   = '0;
					blk_d   = bgf_q;                        // [R14]
				end
			end
			CMBM_RX_RECV: begin
				if (f_valid && f_ready && !blk_q &&
				    ptr_q < 4'(BUF_BYTES)) begin
					bg_d[ptr_q] = f_data;                   // [R5]
					ptr_d       = ptr_q + 4'h1;
				end
				if (i_rx_frame_ok || i_rx_error) begin
					rx_st_d = CMBM_RX_FINISH;
					acc_d   = i_rx_frame_ok && i_rx_accept;
					own_d   = i_rx_own;                     // [R12]
				end
			end
			CMBM_RX_FINISH: begin
				if (f_valid && f_ready && !blk_q &&
				    ptr_q < 4'(BUF_BYTES)) begin
					bg_d[ptr_q] = f_data;
					ptr_d       = ptr_q + 4'h1;
				end else if (!f_valid && !copy_now) begin
					rx_st_d = CMBM_RX_IDLE;
					// Own frames stop here outside loop-back
					if (acc_q && (!own_q || i_loopback)) begin // [R10] [R11]
						if (blk_q) begin
							ovr_d = 1'b1;                   // [R13]
						end else if (!rxf_d) begin
							fg_d  = bg_d;                   // [R7]
							rxf_d = 1'b1;                   // [R6]
						end else begin
							bgf_d = 1'b1;
						end
					end
				end
			end
			default: begin
				rx_st_d = CMBM_RX_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rx_st_q <= CMBM_RX_IDLE;
			ptr_q   <= '0;
			rxf_q   <= 1'b0;
			ovr_q   <= 1'b0;
			bgf_q   <= 1'b0;
			blk_q   <= 1'b0;
			acc_q   <= 1'b0;
			own_q   <= 1'b0;
		end else begin
			rx_st_q <= rx_st_d;
			ptr_q   <= ptr_d;
			rxf_q   <= rxf_d;
			ovr_q   <= ovr_d;
			bgf_q   <= bgf_d;
			blk_q   <= blk_d;
			acc_q   <= acc_d;
			own_q   <= own_d;
		end
	end

	// ----------------------------------------
	// Transmit scheduling
	// ----------------------------------------
	always_comb begin
		txb_d   = txb_q;
		local_priority_field_d  = local_priority_field_q;
		txe_d   = txe_q;
		req_d   = req_q;
		ack_d   = ack_q;
		act_d   = act_q;
		sel_d   = sel_q;
		best    = '0;
		best_ok = 1'b0;
		for (int i = 0; i < `CMBM_TX_BUFS; i++) begin
			rdy[i] = !txe_q[i] && !req_q[i];
			if (rdy[i] && (!best_ok || local_priority_field_q[i] < local_priority_field_q[best])) begin
				best    = 2'(i);                            // [R18]
				best_ok = 1'b1;
			end
		end
		if (i_host_tx_wr && txe_q[i_host_tx_buf] &&
		    i_host_addr < 4'(BUF_BYTES)) begin
			txb_d[i_host_tx_buf][i_host_addr] = i_host_wdata; // [R3]
		end
		if (i_host_local_priority_field_wr && txe_q[i_host_tx_buf]) begin
			local_priority_field_d[i_host_tx_buf] = i_host_wdata;           // [R15]
		end
		for (int i = 0; i < `CMBM_TX_BUFS; i++) begin
			if (i_txe_clr[i] && txe_q[i]) begin
				txe_d[i] = 1'b0;                            // [R16]
				ack_d[i] = 1'b0;
			end
			if (i_abort_set[i] && !txe_q[i]) begin
				req_d[i] = 1'b1;                            // [R23]
			end
			if (req_q[i] && !txe_q[i] &&
			    !(act_q && sel_q == 2'(i))) begin
				txe_d[i] = 1'b1;                            // [R20]
				ack_d[i] = 1'b1;                            // [R21]
				req_d[i] = 1'b0;
			end
		end
		if (act_q && i_tx_done) begin
			txe_d[sel_q] = 1'b1;                            // [R17]
			req_d[sel_q] = 1'b0;                            // [R23]
			ack_d[sel_q] = 1'b0;                            // [R21]
			act_d        = 1'b0;
		end else if (act_q && (i_tx_error || i_arb_lost)) begin
			act_d = 1'b0;                                   // [R12]
		end else if (!act_q && i_arb_start && best_ok) begin
			act_d = 1'b1;                                   // [R19]
			sel_d = best;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			txe_q <= `CMBM_TXE_RST;
			req_q <= '0;
			ack_q <= '0;
			act_q <= 1'b0;
			sel_q <= '0;
			for (int i = 0; i < `CMBM_TX_BUFS; i++) begin
				local_priority_field_q[i] <= `CMBM_LOCAL_PRIORITY_FIELD_RST;
			end
		end else begin
			txe_q  <= txe_d;
			req_q  <= req_d;
			ack_q  <= ack_d;
			act_q  <= act_d;
			sel_q  <= sel_d;
			local_priority_field_q <= local_priority_field_d;
		end
	end

	// Message bytes are plain storage, no reset needed
	always_ff @(posedge i_core_clk) begin
		bg_q  <= bg_d;
		fg_q  <= fg_d;
		txb_q <= txb_d;
	end

	// ----------------------------------------
	// Pins and registered outputs
	// ----------------------------------------
	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pin_q  <= {`CMBM_RECESSIVE, `CMBM_RECESSIVE};
			txo_q  <= '0;
			rxo_q  <= '0;
			rxi_q  <= 1'b0;
			erri_q <= 1'b0;
			txi_q  <= 1'b0;
			alw_q  <= 1'b1;
		end else begin
			pin_q[`CMBM_TX_BIT] <= i_tx_level;              // [R1]
			pin_q[`CMBM_RX_BIT] <= i_port_can_in[`CMBM_RX_BIT]; // [R2]
			txo_q  <= (i_tx_byte_idx < 4'(BUF_BYTES)) ?
			          txb_q[sel_q][i_tx_byte_idx] : '0;
			rxo_q  <= (i_host_rx_addr < 4'(BUF_BYTES)) ?
			          fg_q[i_host_rx_addr] : '0;
			rxi_q  <= rxf_d && i_rxf_ie;                    // [R7]
			erri_q <= ovr_d && i_ovr_ie;                    // [R13]
			txi_q  <= |(txe_d & i_txe_ie);                  // [R17]
			alw_q  <= i_loopback || !act_d;                 // [R10]
		end
	end

	assign o_port_can_out      = {pin_q[`CMBM_TX_BIT], 1'b0};
	assign o_port_can_oe       = `CMBM_PORT_OE;
	assign o_rx_level          = pin_q[`CMBM_RX_BIT];
	assign o_ack_allow         = alw_q;                 // [R10]
	assign o_tx_active         = act_q;
	assign o_tx_sel            = sel_q;
	assign o_tx_byte           = txo_q;
	assign o_host_rx_rdata     = rxo_q;
	assign o_rx_full_flag      = rxf_q;
	assign o_overrun_flag      = ovr_q;
	assign o_tx_empty_flag     = txe_q;
	assign o_abort_request_bit = req_q;
	assign o_abort_ack_bit     = ack_q;
	assign o_rx_irq            = rxi_q;
	assign o_err_irq           = erri_q;
	assign o_tx_irq            = txi_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	tx_pin_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R1]
		##1 o_port_can_out[1] == $past(i_tx_level))
		else $error("transmit pin does not follow level");
	rx_deliver_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R7]
		rx_st_q == CMBM_RX_FINISH && !f_valid && !copy_now && acc_q &&
		!own_q && !blk_q && !rxf_q |=> rxf_q && o_rx_irq == $past(i_rxf_ie))
		else $error("accepted frame not delivered");
	own_frame_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R10]
		rx_st_q == CMBM_RX_FINISH && !f_valid && !copy_now && own_q &&
		!i_loopback && !rxf_q && !i_rxf_clr |=> !rxf_q)
		else $error("own frame reached foreground");
	overrun_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R13]
		rx_st_q == CMBM_RX_FINISH && !f_valid && !copy_now && acc_q &&
		blk_q && (!own_q || i_loopback) |=> ovr_q && $stable(bgf_q))
		else $error("overrun not flagged");
	tx_done_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R17]
		act_q && i_tx_done |=> txe_q[$past(sel_q)] && !act_q &&
		!ack_q[$past(sel_q)])
		else $error("sent buffer not released");
	local_priority_field_pick_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R18]
		$rose(act_q) |-> (!$past(rdy[0]) || local_priority_field_q[sel_q] <= local_priority_field_q[0]) &&
		(!$past(rdy[1]) || local_priority_field_q[sel_q] <= local_priority_field_q[1]) &&
		(!$past(rdy[2]) || local_priority_field_q[sel_q] <= local_priority_field_q[2]))
		else $error("wrong buffer chosen");
	abort_busy_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R20]
		act_q && !i_tx_done |=> !txe_q[$past(sel_q)])
		else $error("frame on bus was aborted");
	abort_grant_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R21]
		req_q[0] && !txe_q[0] && !(act_q && sel_q == 2'h0)
		|=> ack_q[0] && txe_q[0] && !req_q[0])
		else $error("abort not granted");
	rx_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_resetn) // [R22]
		copy_now |=> rxf_q && !bgf_q)
		else $error("receive flag cleared while frame waits");

endmodule : cmbm_top

`default_nettype wire

/* src/cmbm_regs.svh */
`ifndef CMBM_REGS_SVH
`define CMBM_REGS_SVH

// ----------------------------------------
// Storage geometry
// ----------------------------------------
`define CMBM_BUF_BYTES   13
`define CMBM_TX_BUFS     3
`define CMBM_FIFO_DEPTH  8
`define CMBM_FIFO_WIDTH  8

// ----------------------------------------
// Port positions and levels
// ----------------------------------------
`define CMBM_RX_BIT      0
`define CMBM_TX_BIT      1
`define CMBM_DOMINANT    1'b0
`define CMBM_RECESSIVE   1'b1
`define CMBM_PORT_OE     2'h2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CMBM_TXE_RST     3'h7
`define CMBM_LOCAL_PRIORITY_FIELD_RST    8'h00

`endif

/* src/cmbm_pkg.sv */
package cmbm_pkg;

	typedef logic [7:0] cmbm_byte_t;
	typedef logic [1:0] cmbm_idx_t;
	typedef logic [3:0] cmbm_addr_t;

	// Gray order along idle, receive, finish
	typedef enum logic [1:0] {
		CMBM_RX_IDLE   = 2'h0,
		CMBM_RX_RECV   = 2'h1,
		CMBM_RX_FINISH = 2'h3
	} cmbm_rx_e;

endpackage : cmbm_pkg

/* src/cmbm_fifo.sv */
`timescale 1ns/10ps
`default_nettype none

module cmbm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             i_core_clk,
	input  wire logic             i_resetn,
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	output logic                  o_out_valid,
	output logic      [WIDTH-1:0] o_out_data,
	input  wire logic             i_out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wptr_q, wptr_d, rptr_q, rptr_d;
	logic [AW:0]      cnt_q, cnt_d;
	logic             push, pop;

	// ----------------------------------------
	// Pointers
	// ----------------------------------------
	always_comb begin
		push   = i_in_valid && o_in_ready;
		pop    = i_out_ready && o_out_valid;
		wptr_d = push ? ((wptr_q == AW'(DEPTH-1)) ? '0 : wptr_q + 1'b1)
		              : wptr_q;
		rptr_d = pop ? ((rptr_q == AW'(DEPTH-1)) ? '0 : rptr_q + 1'b1)
		             : rptr_q;
		cnt_d  = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge i_core_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wptr_q      <= '0;
			rptr_q      <= '0;
			cnt_q       <= '0;
			o_in_ready  <= 1'b1;
			o_out_valid <= 1'b0;
		end else begin
			wptr_q      <= wptr_d;
			rptr_q      <= rptr_d;
			cnt_q       <= cnt_d;
			// Flags registered so the ports come from flops
			o_in_ready  <= (cnt_d != (AW+1)'(DEPTH));
			o_out_valid <= (cnt_d != '0);
		end
	end

	// Storage flops carry no reset
	always_ff @(posedge i_core_clk) begin
		if (push) begin
			mem_q[wptr_q] <= i_in_data;
		end
	end

	assign o_out_data  = mem_q[rptr_q];

endmodule : cmbm_fifo

`default_nettype wire

/* tb/cmbm_bus_model.sv */
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Transceiver and bus, wired-AND
// ----------------------------------------
module cmbm_bus_model (
	input  wire logic i_tx_pin,
	input  wire logic i_remote_level,
	output logic      o_rx_pin
);
	// Any dominant zero wins the wire, ours echoes back
	assign o_rx_pin = i_tx_pin & i_remote_level;
endmodule : cmbm_bus_model

`default_nettype wire

/* tb/tb_can_message_buffer_manager.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cmbm_regs.svh"

module tb_can_message_buffer_manager;
	import cmbm_pkg::*;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic       clk, rstn, txl, lb, sof, bv, fok, ferr, acc, own;
	logic       arbs, arbl, tdone, terr, twr, pwr, rxclr, ovclr;
	logic       rxie, ovie, remote, rxlev, bready, ackal, tact;
	logic       rx_full_flag, ovr, rxirq, eirq, txirq, rxpin;
	logic [1:0] pout, poe;
	logic [2:0] txeclr, abset, txeie, tx_empty_flag, abrq, abak;
	cmbm_byte_t rbyte, wdata, txbyte, rdata;
	cmbm_idx_t  tbuf, tsel;
	cmbm_addr_t haddr, raddr, tidx;
	int         num_errors, tests_run;

	cmbm_bus_model bus (.i_tx_pin(pout[1]), .i_remote_level(remote),
		.o_rx_pin(rxpin));

	cmbm_top uut (.i_core_clk(clk), .i_resetn(rstn),
		.i_port_can_in({1'b1, rxpin}), .o_port_can_out(pout),
		.o_port_can_oe(poe), .o_rx_level(rxlev), .i_tx_level(txl),
		.i_loopback(lb), .i_rx_sof(sof), .i_rx_byte_valid(bv),
		.i_rx_byte(rbyte), .o_rx_byte_ready(bready),
		.i_rx_frame_ok(fok), .i_rx_error(ferr), .i_rx_accept(acc),
		.i_rx_own(own), .o_ack_allow(ackal), .i_arb_start(arbs),
		.i_arb_lost(arbl), .i_tx_done(tdone), .i_tx_error(terr),
		.o_tx_active(tact), .o_tx_sel(tsel), .i_tx_byte_idx(tidx),
		.o_tx_byte(txbyte), .i_host_tx_wr(twr), .i_host_tx_buf(tbuf),
		.i_host_addr(haddr), .i_host_wdata(wdata), .i_host_local_priority_field_wr(pwr),
		.i_host_rx_addr(raddr), .o_host_rx_rdata(rdata),
		.i_rxf_clr(rxclr), .i_ovr_clr(ovclr), .i_txe_clr(txeclr),
		.i_abort_set(abset), .i_rxf_ie(rxie), .i_ovr_ie(ovie),
		.i_txe_ie(txeie), .o_rx_full_flag(rx_full_flag), .o_overrun_flag(ovr),
		.o_tx_empty_flag(tx_empty_flag), .o_abort_request_bit(abrq),
		.o_abort_ack_bit(abak), .o_rx_irq(rxirq), .o_err_irq(eirq),
		.o_tx_irq(txirq));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string msg);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: %s got %0h exp %0h", $time, msg,
				got, exp);
		end
	endtask : chk

	task automatic print_verdict();
		$display("Checks %0d, errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : print_verdict

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : step

	// Finish state must drain before the next start of frame
	task automatic rx_frame(input cmbm_byte_t base, input logic a,
		input logic o);
		@(posedge clk);
		sof <= 1'b1;
		@(posedge clk);
		sof <= 1'b0;
		for (int i = 0; i < 13; i++) begin
			bv    <= 1'b1;
			rbyte <= base + 8'(i);
			@(negedge clk);
			for (int k = 0; k < 50 && bready !== 1'b1; k++) @(negedge clk);
			@(posedge clk);
		end
		bv  <= 1'b0;
		fok <= 1'b1;
		acc <= a;
		own <= o;
		@(posedge clk);
		fok <= 1'b0;
		step(20);
	endtask : rx_frame

	task automatic rd_fg(input cmbm_addr_t a, input cmbm_byte_t e);
		@(posedge clk);
		raddr <= a;
		@(posedge clk);
		step(1);
		chk(rdata, e, "foreground byte");
	endtask : rd_fg

	task automatic clr_rx();
		@(posedge clk);
		rxclr <= 1'b1;
		@(posedge clk);
		rxclr <= 1'b0;
		step(2);
	endtask : clr_rx

	task automatic load(input cmbm_idx_t b, input cmbm_byte_t base,
		input cmbm_byte_t local_priority_field);
		@(posedge clk);
		twr  <= 1'b1;
		tbuf <= b;
		for (int i = 0; i < 13; i++) begin
			haddr <= 4'(i);
			wdata <= base + 8'(i);
			@(posedge clk);
		end
		twr   <= 1'b0;
		pwr   <= 1'b1;
		wdata <= local_priority_field;
		@(posedge clk);
		pwr       <= 1'b0;
		txeclr[b] <= 1'b1;
		@(posedge clk);
		txeclr <= 3'h0;
		step(0);
	endtask : load

	task automatic arb(input cmbm_idx_t e);
		@(posedge clk);
		arbs <= 1'b1;
		@(posedge clk);
		arbs <= 1'b0;
		step(0);
		chk(tact, 1'b1, "active after arbitration");
		chk(tsel, e, "selected buffer");
	endtask : arb

	task automatic tx_end(input int kind);
		@(posedge clk);
		tdone <= (kind == 0);
		terr  <= (kind == 1);
		arbl  <= (kind == 2);
		@(posedge clk);
		tdone <= 1'b0;
		terr  <= 1'b0;
		arbl  <= 1'b0;
		step(1);
		chk(tact, 1'b0, "idle after end");
	endtask : tx_end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_pins();
		step(0);
		chk(tx_empty_flag, `CMBM_TXE_RST, "empty after reset");
		chk(poe, `CMBM_PORT_OE, "pin enables");
		chk(pout, 8'h2, "recessive idle");
		@(posedge clk);
		txl <= `CMBM_DOMINANT;
		@(posedge clk);
		step(1);
		chk(pout[1], `CMBM_DOMINANT, "dominant out");
		chk(rxlev, 1'b0, "echo on receive bit");
		@(posedge clk);
		txl    <= `CMBM_RECESSIVE;
		remote <= 1'b0;
		@(posedge clk);
		step(1);
		chk(pout[1], `CMBM_RECESSIVE, "recessive out");
		chk(rxlev, 1'b0, "remote dominant seen");
		@(posedge clk);
		remote <= 1'b1;
	endtask : t_pins

	task automatic t_rx();
		rx_frame(8'h10, 1'b1, 1'b0);
		chk(rx_full_flag, 1'b1, "full after good frame");
		chk(rxirq, 1'b1, "receive irq");
		rd_fg(4'h0, 8'h10);
		rd_fg(4'hC, 8'h1C);
		rx_frame(8'h40, 1'b0, 1'b0);
		rx_frame(8'h20, 1'b1, 1'b0);
		chk(ovr, 1'b0, "no overrun yet");
		rx_frame(8'h30, 1'b1, 1'b0);
		chk(ovr, 1'b1, "overrun");
		chk(eirq, 1'b1, "error irq");
		rd_fg(4'h0, 8'h10);
		clr_rx();
		chk(rx_full_flag, 1'b1, "clear refused, held frame");
		rd_fg(4'h5, 8'h25);
		clr_rx();
		chk(rx_full_flag, 1'b0, "cleared");
		@(posedge clk);
		ovclr <= 1'b1;
		@(posedge clk);
		ovclr <= 1'b0;
		step(1);
		chk(ovr, 1'b0, "overrun cleared");
		rx_frame(8'h50, 1'b0, 1'b0);
		chk(rx_full_flag, 1'b0, "rejected frame");
		rx_frame(8'h60, 1'b1, 1'b1);
		chk(rx_full_flag, 1'b0, "own frame kept back");
		@(posedge clk);
		lb <= 1'b1;
		rx_frame(8'h70, 1'b1, 1'b1);
		chk(rx_full_flag, 1'b1, "own frame in loop-back");
		rd_fg(4'h1, 8'h71);
		clr_rx();
		@(posedge clk);
		lb <= 1'b0;
	endtask : t_rx

	task automatic t_tx();
		load(2'h0, 8'h80, 8'h30);
		load(2'h1, 8'h90, 8'h10);
		load(2'h2, 8'hA0, 8'h20);
		chk(tx_empty_flag, 3'h0, "all ready");
		arb(2'h1);
		chk(ackal, 1'b0, "no ack of own frame");
		@(posedge clk);
		tidx <= 4'h0;
		step(1);
		chk(txbyte, 8'h90, "tx byte");
		tx_end(0);
		chk(tx_empty_flag, 3'h2, "sent sets empty");
		chk(txirq, 1'b1, "tx irq");
		arb(2'h2);
		tx_end(1);
		load(2'h1, 8'hC0, 8'h05);
		arb(2'h1);
		tx_end(2);
		rx_frame(8'hB0, 1'b1, 1'b0);
		chk(rx_full_flag, 1'b1, "winner received");
		clr_rx();
		arb(2'h1);
		@(posedge clk);
		abset <= 3'h7;
		@(posedge clk);
		abset <= 3'h0;
		step(2);
		chk(abak, 3'h5, "idle buffers aborted");
		chk(tx_empty_flag, 3'h5, "aborted released");
		chk(abrq, 3'h2, "active abort waits");
		tx_end(0);
		chk(abak, 3'h5, "sent keeps ack low");
		chk(abrq, 3'h0, "requests dropped");
		chk(tx_empty_flag, 3'h7, "all empty");
		@(posedge clk);
		abset <= 3'h2;
		@(posedge clk);
		abset <= 3'h0;
		step(2);
		chk(abrq, 3'h0, "abort on empty ignored");
	endtask : t_tx

	// ----------------------------------------
	// Clock, reset, sequence, watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		{rstn, lb, sof, bv, fok, ferr, acc, own, arbs, arbl} = '0;
		{tdone, terr, twr, pwr, rxclr, ovclr} = '0;
		{txeclr, abset, rbyte, wdata, tbuf, haddr, raddr, tidx} = '0;
		txl        = 1'b1;
		remote     = 1'b1;
		rxie       = 1'b1;
		ovie       = 1'b1;
		txeie      = 3'h7;
		num_errors = 0;
		tests_run  = 0;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		t_pins();
		t_rx();
		t_tx();
		print_verdict();
	end

	// Whole run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		print_verdict();
	end
endmodule : tb_can_message_buffer_manager

`default_nettype wire
